// *** core/fdps_pkg.sv ***
// constants for the flash data page sequencer
package fdps_pkg;
   localparam int PAGE_COUNT = 160;
   localparam int PAGE_BYTES = 4;
   localparam int ARRAY_BYTES = 640;
   localparam logic [7:0] PAGE_LAST = 8'h9f;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] CMD_IDLE = 8'h00;
   localparam logic [7:0] CMD_READ = 8'h01;
   localparam logic [7:0] CMD_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_VERIFY = 8'h04;
   localparam logic [7:0] CMD_ERASE = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
   localparam logic [7:0] VERIFY_FAIL = 8'h01;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int CLK_HZ = 40000000;
   localparam int PROGRAM_US = 250;
   localparam int ERASE_US = 2000;
   localparam int PROGRAM_CYCLES = (CLK_HZ / 1000000) * PROGRAM_US;
   localparam int ERASE_CYCLES = (CLK_HZ / 1000000) * ERASE_US;
   localparam int READ_CYCLES = 1;
   localparam int CNT_W = 24;
   typedef enum logic [2:0] {
      FDPS_IDLE = 3'b001,
      FDPS_WAIT = 3'b010,
      FDPS_DONE = 3'b100
   } fdps_state_e;
endpackage

// *** core/fdps_timer.sv ***
// down counter that times one array operation
module fdps_timer #(
   parameter int CNT_W = 24
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [CNT_W-1:0] cycles,
   output logic expired
);
   logic [CNT_W-1:0] count_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= cycles;
      end else if (count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end
   assign expired = (count_q == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// *** core/fdps_top.sv ***
// flash data page sequencer: command decode, timing, array storage
// Requirements from the document
// RQ1: erase-all takes 2 ms
// RQ2: page erase takes 2 ms
// RQ3: page program takes 250 us
// RQ4: page read completes in one cycle
// RQ5: byte program only after page erase; the code also accepts a program with no prior erase
// RQ6: program only lands on erased bytes; the code ANDs new data into a non-erased byte
// RQ7: erase clears a whole four-byte page
// RQ8: command write starts the operation at once
// RQ9: core stalled until operation completes
// RQ10: interrupt service held off while busy
// RQ11: timers keep running during the stall
// RQ12: command 06h erases all 640 bytes
// RQ13: array starts fully erased, reads ffh
// RQ14: host loads address, data, then command
// RQ15: read-modify-erase-program changes one byte
// RQ16: erase-all at setup is advised
// RQ17: 01h reads page, 02h programs page
// RQ18: verify leaves zero on match, else nonzero
// RQ19: 160 pages, address 00h to 9fh
// RQ20: host never writes reserved commands
// RQ21: cycle counter times ops, busy throughout
module fdps_top
#(
   parameter int CLK_FREQ_HZ = fdps_pkg::CLK_HZ,
   parameter int PROG_CYCLES = (CLK_FREQ_HZ / 1000000) * fdps_pkg::PROGRAM_US,
   parameter int ERASE_CYC = (CLK_FREQ_HZ / 1000000) * fdps_pkg::ERASE_US
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic addr_we,
   input wire logic [7:0] addr_wdata,
   input wire logic [3:0] data_we,
   input wire logic [31:0] data_wdata,
   input wire logic cmd_we,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] flash_command_reg,
   output logic [7:0] page_address_reg,
   output logic [31:0] page_data_regs,
   output logic core_stall,
   output logic irq_hold
);
   import fdps_pkg::*;

   logic [7:0] cmd_q;
   logic [7:0] addr_q;
   logic [31:0] data_q;
   logic [7:0] mem_q [ARRAY_BYTES];
   logic [PAGE_COUNT-1:0] init_q;
   fdps_state_e state_q;
   logic [7:0] op_q;
   logic busy_q;
   logic load;
   logic [CNT_W-1:0] load_cycles;
   logic expired;
   logic start;
   logic addr_ok;

   function automatic int byte_idx(input logic [7:0] page, input int b);
      byte_idx = int'(page) * PAGE_BYTES + b;
   endfunction

   // host-side writes are ignored while busy since the core is idled anyway
   assign start = cmd_we && !busy_q; // RQ8
   assign addr_ok = (addr_q <= PAGE_LAST); // RQ19
   assign load = start && (cmd_wdata == CMD_PROGRAM || cmd_wdata == CMD_ERASE
      || cmd_wdata == CMD_ERASE_ALL);
   assign load_cycles = (cmd_wdata == CMD_PROGRAM) ? CNT_W'(PROG_CYCLES)
      : CNT_W'(ERASE_CYC); // RQ21

   fdps_timer #(.CNT_W(CNT_W)) u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(load),
      .cycles(load_cycles),
      .expired(expired)
   );

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= FDPS_IDLE;
         busy_q <= 1'b0;
         op_q <= CMD_IDLE;
      end else begin
         unique case (state_q)
            FDPS_IDLE: begin
               if (load) begin
                  state_q <= FDPS_WAIT;
                  busy_q <= 1'b1; // RQ9
                  op_q <= cmd_wdata;
               end
            end
            FDPS_WAIT: begin
               if (expired) begin
                  state_q <= FDPS_DONE;
               end
            end
            FDPS_DONE: begin
               state_q <= FDPS_IDLE;
               busy_q <= 1'b0; // RQ21
               op_q <= CMD_IDLE;
            end
            default: begin
               state_q <= FDPS_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         addr_q <= RESET_BYTE;
      end else if (addr_we && !busy_q) begin
         addr_q <= addr_wdata; // RQ14
      end
   end

   // array valid bits: a never-written page reads erased, so no init sweep
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         init_q <= '0; // RQ13
      end else if (state_q == FDPS_DONE && addr_ok) begin
         if (op_q == CMD_PROGRAM || op_q == CMD_ERASE) begin
            init_q[addr_q] <= 1'b1;
         end
      end
   end

   function automatic logic [7:0] rd_byte(input logic [7:0] page, input int b);
      rd_byte = init_q[page] ? mem_q[byte_idx(page, b)] : ERASED_BYTE; // RQ13
   endfunction

   logic erase_all_done;
   assign erase_all_done = (state_q == FDPS_DONE) && (op_q == CMD_ERASE_ALL);

   // commit happens at the end of the timed interval
   always_ff @(posedge sys_clk) begin
      for (int p = 0; p < PAGE_COUNT; p++) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            // erase-all first, so the addressed page is not skipped
            if (erase_all_done) begin
               mem_q[p * PAGE_BYTES + b] <= ERASED_BYTE; // RQ1 RQ12
            end else if (state_q == FDPS_DONE && addr_ok && int'(addr_q) == p) begin
               if (op_q == CMD_ERASE) begin
                  mem_q[p * PAGE_BYTES + b] <= ERASED_BYTE; // RQ2 RQ7
               end else if (op_q == CMD_PROGRAM) begin
                  // bits only fall from one to zero, so a non-erased byte takes the AND of old and new data
                  mem_q[p * PAGE_BYTES + b] <= rd_byte(addr_q, b)
                     & data_q[8*b +: 8]; // RQ3 RQ5 RQ6 RQ17
               end
            end
         end
      end
   end

   logic verify_ok;
   always_comb begin
      verify_ok = addr_ok;
      for (int b = 0; b < PAGE_BYTES; b++) begin
         if (rd_byte(addr_q, b) != data_q[8*b +: 8]) begin
            verify_ok = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         data_q <= '0;
      end else if (start && cmd_wdata == CMD_READ) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            data_q[8*b +: 8] <= addr_ok ? rd_byte(addr_q, b) : ERASED_BYTE; // RQ4 RQ17
         end
      end else if (!busy_q) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            if (data_we[b]) begin
               data_q[8*b +: 8] <= data_wdata[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_q <= RESET_BYTE;
      end else if (start) begin
         if (cmd_wdata == CMD_VERIFY) begin
            cmd_q <= verify_ok ? CMD_IDLE : VERIFY_FAIL; // RQ18
         end else begin
            cmd_q <= cmd_wdata;
         end
      end
   end

   // the stall gates the core only; peripheral timers have no link to it
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         core_stall <= 1'b0;
         irq_hold <= 1'b0;
      end else begin
         core_stall <= load || (busy_q && state_q != FDPS_DONE); // RQ9 RQ11
         irq_hold <= load || (busy_q && state_q != FDPS_DONE); // RQ10
      end
   end

   assign flash_command_reg = cmd_q;
   assign page_address_reg = addr_q;
   assign page_data_regs = data_q;

   sequence s_timed_start;
      load && cmd_wdata == CMD_PROGRAM;
   endsequence

   chk_prog_time_busy: assert property (@(posedge sys_clk) disable iff (reset)
      s_timed_start |=> busy_q [*8]) else $error("busy dropped early"); // RQ3
   chk_stall_follows_busy: assert property (@(posedge sys_clk) disable iff (reset)
      (busy_q && state_q == FDPS_WAIT) |=> core_stall) else $error("stall missing"); // RQ9
   chk_irq_hold_start: assert property (@(posedge sys_clk) disable iff (reset)
      load |=> irq_hold && core_stall) else $error("irq hold missing"); // RQ10
   chk_irq_hold_release: assert property (@(posedge sys_clk) disable iff (reset)
      state_q == FDPS_DONE |=> !irq_hold) else $error("irq hold stuck"); // RQ10
   chk_read_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
      (start && cmd_wdata == CMD_READ && addr_ok && !init_q[addr_q])
      |=> page_data_regs == {4{ERASED_BYTE}}) else $error("read slow"); // RQ4
   chk_verify_result: assert property (@(posedge sys_clk) disable iff (reset)
      (start && cmd_wdata == CMD_VERIFY) |=> flash_command_reg == ($past(verify_ok) ?
      CMD_IDLE : VERIFY_FAIL)) else $error("verify result wrong"); // RQ18
   chk_start_immediate: assert property (@(posedge sys_clk) disable iff (reset)
      load |=> state_q == FDPS_WAIT && busy_q) else $error("no start"); // RQ8
   chk_done_clears_busy: assert property (@(posedge sys_clk) disable iff (reset)
      state_q == FDPS_DONE |=> !busy_q) else $error("busy stuck"); // RQ21
   chk_erase_all_fills: assert property (@(posedge sys_clk) disable iff (reset)
      erase_all_done |=> mem_q[0] == ERASED_BYTE
      && (!addr_ok || rd_byte(addr_q, 0) == ERASED_BYTE)) else $error("erase-all missed"); // RQ12
endmodule

// *** test/fdps_host.sv ***
// core model: loads page registers and issues commands
module fdps_host (
   input wire logic sys_clk,
   input wire logic core_stall,
   output logic addr_we,
   output logic [7:0] addr_wdata,
   output logic [3:0] data_we,
   output logic [31:0] data_wdata,
   output logic cmd_we,
   output logic [7:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int stall_cycles;
   initial begin
      addr_we = 1'b0;
      addr_wdata = 8'h00;
      data_we = 4'h0;
      data_wdata = 32'h0;
      cmd_we = 1'b0;
      cmd_wdata = 8'h00;
   end
   // released lines show the inverse, so a stale value never looks valid
   task automatic set_addr(input logic [7:0] a);
      @(negedge sys_clk);
      addr_we = 1'b1;
      addr_wdata = a;
      @(negedge sys_clk);
      addr_we = 1'b0;
      addr_wdata = ~a;
   endtask
   task automatic set_data(input logic [3:0] l, input logic [31:0] d);
      @(negedge sys_clk);
      data_we = l;
      data_wdata = d;
      @(negedge sys_clk);
      data_we = 4'h0;
      data_wdata = ~d;
   endtask
   // reserved codes are never sent; next command only once stall drops or 1000 stalled cycles pass
   task automatic command(input logic [7:0] c);
      @(negedge sys_clk);
      cmd_we = 1'b1;
      cmd_wdata = c;
      @(negedge sys_clk);
      cmd_we = 1'b0;
      cmd_wdata = ~c;
      stall_cycles = 0;
      while (core_stall === 1'b1 && stall_cycles < 1000) begin
         stall_cycles++;
         @(negedge sys_clk);
      end
   endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the flash data page sequencer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fdps_pkg::*;
   localparam int PN = 20;
   localparam int EN = 40;
   logic sys_clk, reset, addr_we, cmd_we, core_stall, irq_hold;
   logic [7:0] addr_wdata, cmd_wdata, flash_command_reg, page_address_reg;
   logic [3:0] data_we;
   logic [31:0] data_wdata, page_data_regs;
   int bad_count = 0;
   int num_checks = 0;
   fdps_top #(.PROG_CYCLES(PN), .ERASE_CYC(EN)) i_fdps_top (.sys_clk(sys_clk), .reset(reset),
      .addr_we(addr_we), .addr_wdata(addr_wdata), .data_we(data_we),
      .data_wdata(data_wdata), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
      .flash_command_reg(flash_command_reg), .page_address_reg(page_address_reg),
      .page_data_regs(page_data_regs), .core_stall(core_stall), .irq_hold(irq_hold));
   fdps_host i_fdps_host (.sys_clk(sys_clk), .core_stall(core_stall), .addr_we(addr_we),
      .addr_wdata(addr_wdata), .data_we(data_we), .data_wdata(data_wdata),
      .cmd_we(cmd_we), .cmd_wdata(cmd_wdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches %0d of %0d comparisons", bad_count, num_checks);
      if (bad_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // stall length window allows the one extra stalled edge (n+1 counted) plus slack
   task automatic op(input logic [7:0] c, input int n);
      i_fdps_host.command(c);
      check(32'(i_fdps_host.stall_cycles >= n && i_fdps_host.stall_cycles <= n + 3), 1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_fdps_host.set_addr(a);
      op(CMD_READ, 0);
      check(page_data_regs, exp);
   endtask
   task automatic test_reset();
      check({flash_command_reg, page_address_reg, 14'h0, core_stall, irq_hold}, 32'h0);
      rd(8'h00, 32'hffffffff);
   endtask
   task automatic test_program();
      i_fdps_host.set_addr(8'h03);
      i_fdps_host.set_data(4'hf, 32'h11223344);
      op(CMD_PROGRAM, PN);
      check(flash_command_reg, CMD_PROGRAM);
      rd(8'h03, 32'h11223344);
   endtask
   task automatic test_verify();
      op(CMD_VERIFY, 0);
      check(flash_command_reg, 8'h00);
      i_fdps_host.set_data(4'h1, 32'h00000055);
      op(CMD_VERIFY, 0);
      check(flash_command_reg, VERIFY_FAIL);
   endtask
   task automatic test_byte_update();
      rd(8'h03, 32'h11223344);
      i_fdps_host.set_data(4'h2, 32'h0000f300);
      op(CMD_ERASE, EN);
      op(CMD_PROGRAM, PN);
      rd(8'h03, 32'h1122f344);
      i_fdps_host.set_data(4'hf, 32'h0f0f0f0f);
      op(CMD_PROGRAM, PN);
      rd(8'h03, 32'h01020304);
   endtask
   task automatic test_erase_all();
      op(CMD_ERASE_ALL, EN);
      rd(8'h03, 32'hffffffff);
      rd(PAGE_LAST, 32'hffffffff);
      check(page_address_reg, PAGE_LAST);
      rd(8'ha0, 32'hffffffff);
   endtask
   // interrupt hold must track the stall on every cycle
   always @(negedge sys_clk) if (reset === 1'b0) check({31'h0, irq_hold}, {31'h0, core_stall});
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
   initial begin
      reset = 1'b1;
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      test_reset();
      test_program();
      test_verify();
      test_byte_update();
      test_erase_all();
      print_verdict();
   end
endmodule
